/* design/cpma_pkg.sv */
// constants and carrier types for the cpu port and module access fabric
//
// Functional notes
// - hold the processor in reset 250 us after power-on is reached
// - power-on reset forces every processor register to its default
// - power-on reset clears every module power-enable bit
// - sixteen processor registers, each a 16-bit word
// - five registers have fixed roles, the others are general purpose
// - halted processor: host reads accumulator, pointer and instruction word
// - other processor registers are not visible to the serial host
// - sixteen 16-bit ports, directly reachable by the serial host
// - ports move to and from the accumulator only by port instructions
// - no other instruction reads or changes any port
// - last three ports are the only path to module registers
// - config holds settings, data holds results, control starts or powers
// - temperature conversion always uses four times the 1.25 V reference
// - temperature result is a 16-bit two's-complement word
// - execution and conversion stay in step with the system clock
// - clock comes from the internal or an external 250 MHz source
// - a timer spaces converter samples at uniform intervals
`default_nettype none
package cpma_pkg;
  // =========================================================
  // sizes and timing
  localparam int CPMA_W = 16;
  localparam int CPMA_NREG = 16;
  localparam int CPMA_CLK_PS = 4000;
  localparam int CPMA_POR_HOLD_US = 250;
  localparam int CPMA_POR_HOLD_CYC =
    (CPMA_POR_HOLD_US * 1000000 + CPMA_CLK_PS - 1) / CPMA_CLK_PS;
  localparam logic [15:0] CPMA_RST_WORD = 16'h0000;
  // =========================================================
  // fixed-role registers
  localparam logic [3:0] CPMA_REG_ACC = 4'h0;
  localparam logic [3:0] CPMA_REG_PTR = 4'h1;
  localparam logic [3:0] CPMA_REG_LOOP = 4'h2;
  localparam logic [3:0] CPMA_REG_MULH = 4'h3;
  localparam logic [3:0] CPMA_REG_STAT = 4'h4;
  // =========================================================
  // indirect module ports and module register map
  localparam logic [3:0] CPMA_PORT_D = 4'hd;
  localparam logic [3:0] CPMA_PORT_E = 4'he;
  localparam logic [3:0] CPMA_PORT_F = 4'hf;
  localparam int CPMA_CMD_WR_BIT = 15;
  localparam logic [3:0] CPMA_MREG_CFG1 = 4'h0;
  localparam logic [3:0] CPMA_MREG_CFG2 = 4'h1;
  localparam logic [3:0] CPMA_MREG_CFGT = 4'h2;
  localparam logic [3:0] CPMA_MREG_ADC_CTRL = 4'h3;
  localparam logic [3:0] CPMA_MREG_DATA1 = 4'h4;
  localparam logic [3:0] CPMA_MREG_DATA2 = 4'h5;
  localparam logic [3:0] CPMA_MREG_DATAT = 4'h6;
  localparam logic [3:0] CPMA_MREG_TMR = 4'h7;
  localparam logic [3:0] CPMA_MREG_PWR = 4'h8;
  localparam int CPMA_TMR_RUN_BIT = 15;
  localparam logic [1:0] CPMA_REF_BG4 = 2'h2;
  // =========================================================
  // serial host frame: 8 command bits then 16 data bits
  localparam logic [4:0] CPMA_CMD_BITS = 5'h08;
  localparam logic [4:0] CPMA_FRAME_BITS = 5'h18;

  typedef enum logic [3:0] {
    CPMA_HOP_PORT_WR = 4'b0000,
    CPMA_HOP_PORT_RD = 4'b0001,
    CPMA_HOP_ACC_RD = 4'b0010,
    CPMA_HOP_PTR_RD = 4'b0011,
    CPMA_HOP_INSTR_RD = 4'b0100,
    CPMA_HOP_HALT = 4'b0101,
    CPMA_HOP_RUN = 4'b0110
  } cpma_hop_e;

  typedef enum logic [2:0] {
    CPMA_COP_NOP = 3'b000,
    CPMA_COP_REG_WR = 3'b001,
    CPMA_COP_REG_RD = 3'b010,
    CPMA_COP_PORT_RD = 3'b011,
    CPMA_COP_PORT_WR = 3'b100
  } cpma_cop_e;

  typedef struct packed {
    logic valid;
    cpma_cop_e op;
    logic [3:0] idx;
    logic [15:0] data;
  } cpma_cpu_req_s;

  typedef struct packed {
    logic [15:0] acc;
    logic [15:0] ptr;
    logic [15:0] rd_data;
    logic run;
  } cpma_cpu_out_s;

  typedef struct packed {
    logic [2:0] chan;
    logic [1:0] ref_sel;
    logic start;
  } cpma_adc_out_s;

  typedef struct packed {
    logic [1:0] cs_n_s;
    logic [1:0] sclk_s;
    logic [1:0] di_s;
    logic [1:0] cksel_s;
    logic sclk_d;
    logic cs_n_d;
    logic [4:0] bit_cnt;
    logic [23:0] rx;
    logic [15:0] tx;
    logic do_bit;
    logic [16:0] por_cnt;
    logic por_done;
    logic halted;
    logic adc_busy;
    logic [15:0] tmr_cnt;
    logic tick;
    logic ext_clk;
    logic [CPMA_NREG-1:0][15:0] regs;
    logic [CPMA_NREG-1:0][15:0] ports;
    logic [CPMA_NREG-1:0][15:0] mregs;
    logic [15:0] instr;
    cpma_cpu_out_s cpu;
    cpma_adc_out_s adc;
  } cpma_state_s;
endpackage
`default_nettype wire

/* design/cpma_core.sv */
// cpu register file, port fabric, module registers and serial debug access
`default_nettype none
module cpma_core
  import cpma_pkg::*;
#(
  parameter int POR_HOLD_CYC = CPMA_POR_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clock_sel_pin,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_di,
  output logic spi_do,
  output logic spi_do_oe,
  input wire cpma_cpu_req_s cpu_req,
  input wire logic [15:0] flash_instr,
  output cpma_cpu_out_s cpu_out,
  input wire logic adc_done,
  input wire logic [15:0] adc_result,
  output cpma_adc_out_s adc_out,
  output logic [15:0] module_power,
  output logic sample_tick,
  output logic ext_clk_sel
);

  cpma_state_s st_reg;
  cpma_state_s st_next;

  // =========================================================
  // combinational next state
  always_comb begin
    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic [15:0] fport_cmd;
    logic fport_wr;
    logic [3:0] midx;
    logic [23:0] rx_new;
    logic [15:0] ctrl;
    logic [1:0] cfg_ref;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    frame_start = 1'b0;
    fport_cmd = 16'h0000;
    fport_wr = 1'b0;
    midx = 4'h0;
    rx_new = 24'h000000;
    ctrl = 16'h0000;
    cfg_ref = 2'h0;
    st_next = st_reg;

    // pins pass two flops; only stage 2 feeds the edge logic
    st_next.cs_n_s = {st_reg.cs_n_s[0], spi_cs_n};
    st_next.sclk_s = {st_reg.sclk_s[0], spi_sclk};
    st_next.di_s = {st_reg.di_s[0], spi_di};
    st_next.cksel_s = {st_reg.cksel_s[0], clock_sel_pin};
    st_next.sclk_d = st_reg.sclk_s[1];
    st_next.cs_n_d = st_reg.cs_n_s[1];
    st_next.ext_clk = st_reg.cksel_s[1];
    sclk_rise = st_reg.sclk_s[1] & ~st_reg.sclk_d;
    sclk_fall = ~st_reg.sclk_s[1] & st_reg.sclk_d;
    frame_start = ~st_reg.cs_n_s[1] & st_reg.cs_n_d;
    st_next.adc.start = 1'b0;
    st_next.tick = 1'b0;

    // power-on hold before execution may begin
    if (!st_reg.por_done) begin
      if (st_reg.por_cnt == 17'(POR_HOLD_CYC - 1)) begin
        st_next.por_done = 1'b1;
      end else begin
        st_next.por_cnt = st_reg.por_cnt + 17'h00001;
      end
    end

    // =========================================================
    // processor requests, honoured only while running
    if (cpu_req.valid && st_reg.cpu.run) begin
      case (cpu_req.op)
        CPMA_COP_REG_WR: begin
          st_next.regs[cpu_req.idx] = cpu_req.data;
        end
        CPMA_COP_REG_RD: begin
          st_next.cpu.rd_data = st_reg.regs[cpu_req.idx];
        end
        CPMA_COP_PORT_RD: begin
          st_next.regs[CPMA_REG_ACC] = st_reg.ports[cpu_req.idx];
        end
        CPMA_COP_PORT_WR: begin
          st_next.ports[cpu_req.idx] = st_reg.regs[CPMA_REG_ACC];
          if (cpu_req.idx == CPMA_PORT_F) begin
            fport_wr = 1'b1;
            fport_cmd = st_reg.regs[CPMA_REG_ACC];
          end
        end
        default: begin
        end
      endcase
    end

    // =========================================================
    // serial host: command byte, then 16 data bits msb first
    if (st_reg.cs_n_s[1]) begin
      st_next.bit_cnt = 5'h00;
    end else if (frame_start) begin
      st_next.bit_cnt = 5'h00;
      st_next.rx = 24'h000000;
    end else if (sclk_rise && st_reg.bit_cnt != CPMA_FRAME_BITS) begin
      rx_new = {st_reg.rx[22:0], st_reg.di_s[1]};
      st_next.rx = rx_new;
      st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
      if (st_reg.bit_cnt == CPMA_CMD_BITS - 5'h01) begin
        case (rx_new[7:4])
          CPMA_HOP_PORT_RD: st_next.tx = st_reg.ports[rx_new[3:0]];
          // debug reads carry no validity flag; host halts first
          CPMA_HOP_ACC_RD: st_next.tx = st_reg.regs[CPMA_REG_ACC];
          CPMA_HOP_PTR_RD: st_next.tx = st_reg.regs[CPMA_REG_PTR];
          CPMA_HOP_INSTR_RD: st_next.tx = st_reg.instr;
          CPMA_HOP_HALT: st_next.halted = 1'b1;
          CPMA_HOP_RUN: st_next.halted = 1'b0;
          // any other register stays hidden from the host
          default: st_next.tx = 16'h0000;
        endcase
      end
      if (st_reg.bit_cnt == CPMA_FRAME_BITS - 5'h01 &&
          rx_new[23:20] == CPMA_HOP_PORT_WR) begin
        // host write wins over a processor port write in the same cycle
        st_next.ports[rx_new[19:16]] = rx_new[15:0];
        if (rx_new[19:16] == CPMA_PORT_F) begin
          fport_wr = 1'b1;
          fport_cmd = rx_new[15:0];
        end
      end
    end
    if (sclk_fall && !st_reg.cs_n_s[1] && st_reg.bit_cnt >= CPMA_CMD_BITS) begin
      st_next.do_bit = st_reg.tx[15];
      st_next.tx = {st_reg.tx[14:0], 1'b0};
    end

    // =========================================================
    // indirect module access: f holds command, d write data, e read data
    if (fport_wr) begin
      midx = fport_cmd[3:0];
      if (fport_cmd[CPMA_CMD_WR_BIT]) begin
        // result registers are written only by the converter
        if (midx != CPMA_MREG_DATA1 && midx != CPMA_MREG_DATA2 &&
            midx != CPMA_MREG_DATAT) begin
          st_next.mregs[midx] = st_next.ports[CPMA_PORT_D];
        end
        if (midx == CPMA_MREG_ADC_CTRL &&
            st_next.ports[CPMA_PORT_D][2:0] != 3'h0) begin
          st_next.adc_busy = 1'b1;
          st_next.adc.start = 1'b1;
        end
      end else begin
        st_next.ports[CPMA_PORT_E] = st_reg.mregs[midx];
      end
    end

    // =========================================================
    // converter channel and reference steering
    ctrl = st_next.mregs[CPMA_MREG_ADC_CTRL];
    st_next.adc.chan = ctrl[2:0];
    if (ctrl[2]) begin
      st_next.adc.ref_sel = CPMA_REF_BG4;
    end else if (ctrl[1]) begin
      cfg_ref = st_next.mregs[CPMA_MREG_CFG2][1:0];
      st_next.adc.ref_sel = cfg_ref;
    end else begin
      cfg_ref = st_next.mregs[CPMA_MREG_CFG1][1:0];
      st_next.adc.ref_sel = cfg_ref;
    end
    if (adc_done && st_reg.adc_busy) begin
      st_next.adc_busy = 1'b0;
      if (st_reg.mregs[CPMA_MREG_ADC_CTRL][2]) begin
        st_next.mregs[CPMA_MREG_DATAT] = adc_result;
      end else if (st_reg.mregs[CPMA_MREG_ADC_CTRL][1]) begin
        st_next.mregs[CPMA_MREG_DATA2] = adc_result;
      end else begin
        st_next.mregs[CPMA_MREG_DATA1] = adc_result;
      end
      st_next.mregs[CPMA_MREG_ADC_CTRL][2:0] = 3'h0;
    end

    // =========================================================
    // sample timer: reload value sets the tick spacing
    if (st_reg.mregs[CPMA_MREG_PWR][CPMA_TMR_RUN_BIT]) begin
      if (st_reg.tmr_cnt == 16'h0000) begin
        st_next.tmr_cnt = st_reg.mregs[CPMA_MREG_TMR];
        st_next.tick = 1'b1;
      end else begin
        st_next.tmr_cnt = st_reg.tmr_cnt - 16'h0001;
      end
    end else begin
      st_next.tmr_cnt = st_reg.mregs[CPMA_MREG_TMR];
    end

    // =========================================================
    // run gate and debug snapshot; conversions also stall the cpu
    st_next.cpu.run = st_next.por_done & ~st_next.halted &
                      ~st_next.adc_busy;
    if (st_reg.cpu.run) begin
      st_next.instr = flash_instr;
    end
    st_next.cpu.acc = st_next.regs[CPMA_REG_ACC];
    st_next.cpu.ptr = st_next.regs[CPMA_REG_PTR];
  end

  // =========================================================
  // state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.cs_n_s <= 2'b11;
      st_reg.cs_n_d <= 1'b1;
      for (int i = 0; i < CPMA_NREG; i++) begin
        st_reg.regs[i] <= CPMA_RST_WORD;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // =========================================================
  // outputs straight from the state flops
  assign spi_do = st_reg.do_bit;
  assign spi_do_oe = ~st_reg.cs_n_s[1];
  assign cpu_out = st_reg.cpu;
  assign adc_out = st_reg.adc;
  assign module_power = st_reg.mregs[CPMA_MREG_PWR];
  assign sample_tick = st_reg.tick;
  assign ext_clk_sel = st_reg.ext_clk;

endmodule
`default_nettype wire

/* tb/cpma_asserts.sv */
// checker for accumulator and pointer writes, power-on hold, serial output enable and converter outputs
`default_nettype none
module cpma_asserts
  import cpma_pkg::*;
#(
  parameter int POR_HOLD_CYC = CPMA_POR_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clock_sel_pin,
  input wire logic spi_cs_n,
  input wire logic spi_do_oe,
  input wire cpma_cpu_req_s cpu_req,
  input wire cpma_cpu_out_s cpu_out,
  input wire cpma_adc_out_s adc_out,
  input wire logic [15:0] module_power,
  input wire logic sample_tick,
  input wire logic ext_clk_sel
);
  // ==========================================================
  // helper count of cycles since reset release
  logic [16:0] rel_cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rel_cnt_reg <= '0;
    end else if (rel_cnt_reg != '1) begin
      rel_cnt_reg <= rel_cnt_reg + 17'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence acc_wr_s;
    cpu_out.run && cpu_req.valid && cpu_req.op == CPMA_COP_REG_WR
      && cpu_req.idx == CPMA_REG_ACC;
  endsequence
  sequence ptr_wr_s;
    cpu_out.run && cpu_req.valid && cpu_req.op == CPMA_COP_REG_WR
      && cpu_req.idx == CPMA_REG_PTR;
  endsequence
  AST_POR_HOLD: assert property (
    cpu_out.run |-> rel_cnt_reg >= POR_HOLD_CYC)
    else $error("processor ran before the hold time");
  AST_RST_CLEAR: assert property (disable iff (1'b0)
    sys_rst |=> cpu_out == '0 && module_power == '0 && adc_out == '0)
    else $error("outputs not cleared by reset");
  AST_ACC_WR: assert property (
    acc_wr_s |=> cpu_out.acc == $past(cpu_req.data))
    else $error("accumulator write lost");
  AST_PTR_WR: assert property (
    ptr_wr_s |=> cpu_out.ptr == $past(cpu_req.data))
    else $error("pointer write lost");
  AST_STALL: assert property (
    !cpu_out.run |=> $stable(cpu_out.acc) && $stable(cpu_out.ptr))
    else $error("registers changed while stopped");
  AST_START_PULSE: assert property (
    adc_out.start |=> !adc_out.start)
    else $error("start longer than one cycle");
  AST_TEMP_REF: assert property (
    adc_out.start && adc_out.chan[2] |-> adc_out.ref_sel == CPMA_REF_BG4)
    else $error("temperature reference not forced");
  AST_CONV_STOP: assert property (
    adc_out.start |-> ##[0:2] !cpu_out.run)
    else $error("processor kept running in conversion");
  AST_OE_ON: assert property (
    $fell(spi_cs_n) ##1 !spi_cs_n [*3] |=> spi_do_oe)
    else $error("output not enabled while selected");
  AST_OE_OFF: assert property (
    $rose(spi_cs_n) ##1 spi_cs_n [*3] |=> !spi_do_oe)
    else $error("output driven while deselected");
  AST_CLK_SEL: assert property (
    clock_sel_pin [*4] |=> ext_clk_sel)
    else $error("clock select not followed");
  AST_TICK_RUN: assert property (
    sample_tick |-> module_power[15] || $past(module_power[15]))
    else $error("tick while timer stopped");
endmodule
`default_nettype wire

/* tb/cpma_host_model.sv */
// serial debug host that frames commands into the device
`default_nettype none
module cpma_host_model (
  output logic cs_n,
  output logic sclk,
  output logic di,
  input wire logic spi_do
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 24;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    di = 1'b0;
  end
  // ==========================================================
  // one 24-bit frame; sclk stands still between frames
  task automatic frame(input logic [7:0] cmd, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd};
    rd = 16'h0000;
    cs_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      di = sh[23 - i];
      #HALF;
      if (i >= 8) begin
        rd = {rd[14:0], spi_do};
      end
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
    end
    #HALF;
    cs_n = 1'b1;
    // released data line must not look like a held bit
    di = ~di;
    #(2 * HALF);
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// top bench: debug host, processor requests and module access
`default_nettype none
module tb_top
  import cpma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 20;
  localparam int LIMIT = 40000;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clock_sel_pin = 1'b0;
  logic spi_cs_n, spi_sclk, spi_di, spi_do, spi_do_oe;
  logic adc_done = 1'b0;
  logic [15:0] adc_result = 16'h0000;
  logic [15:0] flash_instr = 16'h0000;
  logic [15:0] module_power, rd, d, acc_m;
  logic sample_tick, ext_clk_sel;
  cpma_cpu_req_s cpu_req = '0;
  cpma_cpu_out_s cpu_out;
  cpma_adc_out_s adc_out;
  cpma_adc_out_s st_seen = '0;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  int pm [16];
  initial forever #2 clk_sys = ~clk_sys;
  cpma_core #(.POR_HOLD_CYC(POR)) cpma_core_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .clock_sel_pin(clock_sel_pin), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_di(spi_di), .spi_do(spi_do),
    .spi_do_oe(spi_do_oe), .cpu_req(cpu_req), .flash_instr(flash_instr),
    .cpu_out(cpu_out), .adc_done(adc_done), .adc_result(adc_result),
    .adc_out(adc_out), .module_power(module_power),
    .sample_tick(sample_tick), .ext_clk_sel(ext_clk_sel));
  cpma_host_model cpma_host_model_inst (.cs_n(spi_cs_n), .sclk(spi_sclk),
    .di(spi_di), .spi_do(spi_do));
  // ==========================================================
  // shared tasks
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (adc_out.start === 1'b1) begin
      st_seen <= adc_out;
    end
    if (cyc == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic host(input cpma_hop_e op, input logic [3:0] a,
                      input logic [15:0] wd, output logic [15:0] r);
    cpma_host_model_inst.frame({op, a}, wd, r);
  endtask
  task automatic cpu(input cpma_cop_e op, input logic [3:0] i,
                     input logic [15:0] v);
    @(posedge clk_sys);
    cpu_req <= '{1'b1, op, i, v};
    @(posedge clk_sys);
    cpu_req <= '0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic mwr(input logic [3:0] r, input logic [15:0] v);
    logic [15:0] x;
    host(CPMA_HOP_PORT_WR, CPMA_PORT_D, v, x);
    host(CPMA_HOP_PORT_WR, CPMA_PORT_F, {12'h800, r}, x);
  endtask
  task automatic mrd(input logic [3:0] r, output logic [15:0] v);
    host(CPMA_HOP_PORT_WR, CPMA_PORT_F, {12'h000, r}, v);
    host(CPMA_HOP_PORT_RD, CPMA_PORT_E, 16'h0000, v);
  endtask
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (sample_tick !== 1'b1 && c < 200);
  endtask
  initial begin
    void'($urandom(32'h41da));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk(cpu_out.acc, 16'h0000);
    chk(module_power, 16'h0000);
    n = 0;
    while (cpu_out.run !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk({15'h0, n >= POR && n <= POR + 2}, 16'h0001);
    $display("reset test done");
    @(posedge clk_sys);
    flash_instr <= 16'($urandom);
    clock_sel_pin <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      pm[i] = int'($urandom & 32'hffff);
      host(CPMA_HOP_PORT_WR, 4'(i), 16'(pm[i]), rd);
    end
    for (int i = 0; i < 13; i++) begin
      host(CPMA_HOP_PORT_RD, 4'(i), 16'h0000, rd);
      chk(rd, 16'(pm[i]));
    end
    $display("port test done");
    d = 16'($urandom);
    cpu(CPMA_COP_REG_WR, CPMA_REG_ACC, d);
    chk(cpu_out.acc, d);
    cpu(CPMA_COP_PORT_WR, 4'h5, 16'h0000);
    host(CPMA_HOP_PORT_RD, 4'h5, 16'h0000, rd);
    chk(rd, d);
    cpu(CPMA_COP_PORT_RD, 4'h7, 16'h0000);
    acc_m = 16'(pm[7]);
    chk(cpu_out.acc, acc_m);
    cpu(CPMA_COP_REG_WR, 4'h9, ~d);
    cpu(CPMA_COP_REG_RD, 4'h9, 16'h0000);
    chk(cpu_out.rd_data, ~d);
    cpu(CPMA_COP_REG_WR, CPMA_REG_PTR, d ^ 16'h00ff);
    chk(cpu_out.ptr, d ^ 16'h00ff);
    host(CPMA_HOP_PORT_RD, 4'h7, 16'h0000, rd);
    chk(rd, 16'(pm[7]));
    $display("processor test done");
    host(CPMA_HOP_HALT, 4'h0, 16'h0000, rd);
    chk({15'h0, cpu_out.run}, 16'h0000);
    cpu(CPMA_COP_REG_WR, CPMA_REG_ACC, ~acc_m);
    host(CPMA_HOP_ACC_RD, 4'h0, 16'h0000, rd);
    chk(rd, acc_m);
    host(CPMA_HOP_PTR_RD, 4'h0, 16'h0000, rd);
    chk(rd, d ^ 16'h00ff);
    host(CPMA_HOP_INSTR_RD, 4'h0, 16'h0000, rd);
    chk(rd, flash_instr);
    host(cpma_hop_e'(4'h7), 4'h2, 16'h0000, rd);
    chk(rd, 16'h0000);
    host(CPMA_HOP_RUN, 4'h0, 16'h0000, rd);
    $display("debug test done");
    mwr(CPMA_MREG_DATA1, 16'h1234);
    mrd(CPMA_MREG_DATA1, rd);
    chk(rd, 16'h0000);
    mwr(CPMA_MREG_CFGT, 16'h0000);
    mwr(CPMA_MREG_ADC_CTRL, 16'h0004);
    chk({13'h0, st_seen.chan}, 16'h0004);
    chk({14'h0, st_seen.ref_sel}, {14'h0, CPMA_REF_BG4});
    d = 16'($urandom) | 16'h8000;
    @(posedge clk_sys);
    adc_result <= d;
    adc_done <= 1'b1;
    @(posedge clk_sys);
    adc_done <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({15'h0, cpu_out.run}, 16'h0001);
    mrd(CPMA_MREG_DATAT, rd);
    chk(rd, d);
    mrd(CPMA_MREG_ADC_CTRL, rd);
    chk(rd & 16'h0007, 16'h0000);
    $display("conversion test done");
    mwr(CPMA_MREG_TMR, 16'h0005);
    mwr(CPMA_MREG_PWR, 16'h8000);
    chk(module_power, 16'h8000);
    wait_tick(n);
    wait_tick(n);
    chk(16'(n), 16'h0006);
    mwr(CPMA_MREG_PWR, 16'h0000);
    chk(module_power, 16'h0000);
    chk({15'h0, ext_clk_sel}, 16'h0001);
    @(posedge clk_sys);
    clock_sel_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk({15'h0, ext_clk_sel}, 16'h0000);
    $display("timer test done");
    complete_run();
  end
endmodule
bind cpma_core cpma_asserts #(.POR_HOLD_CYC(POR_HOLD_CYC)) cpma_asserts_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .clock_sel_pin(clock_sel_pin),
  .spi_cs_n(spi_cs_n), .spi_do_oe(spi_do_oe), .cpu_req(cpu_req),
  .cpu_out(cpu_out), .adc_out(adc_out), .module_power(module_power),
  .sample_tick(sample_tick), .ext_clk_sel(ext_clk_sel));
`default_nettype wire
